// file: design/tca_ctrl.sv
// Overview of operation
// - a configuration bit enables the limit warning; disabled, comparisons never set it, but level mode still clears it on each result
// - when enabled, every finished result is compared to the low and high limit
// - a result outside the limits asserts the warning pin per pin mode
// - rise since previous result above unsigned threshold sets slew status; falls ignored
// - the rise check runs only in continuous conversion mode
// - checksum-requested read with valid length appends a 16-bit checksum word
// - checksum write mismatch drops the write and sets the checksum error flag
// - mode bit 0 runs conversions back to back: active conversion then standby
// - result register updates as soon as an active conversion ends, unless a config write lands in its last cycle
// - conversion-done flag is set whenever an active conversion completes without a config write in its last cycle
// - reading status or result clears the conversion-done flag
// - with done routing enabled the pin also shows the conversion-done flag
// - standby idles measurement but spi transactions are still served
// - active time fixed; a 3-bit field selects the whole conversion period
// - writing mode bit 1 shuts down at once and discards a partial conversion
// - mode changes keep status bits, and the pin stays until a status read in latched mode, until a later result in level mode
// - shutdown never newly raises slew status; a set one stays until a status read in latched mode, until a continuous result in level mode
// - writing single-shot 1 starts a fresh conversion, dropping any partial one
// - single-shot end: shutdown, mode bit set, single-shot bit cleared, done flag set
// - single-shot rewrite during active conversion restarts it; result unchanged
// - command bit 14 asks checksum, honoured only if length bits 13:10 in 1..1010b
// - changing pin mode between latched and level clears status and the pin
// - latched mode: status read clears event flags and releases the pin
`timescale 1ns/10ps
`include "tca_map.svh"

module tca_ctrl #(
	parameter int TICK_CYCLES = `TCA_TICK_PERIOD_NS / `TCA_CLK_PERIOD_NS,
	parameter int TEMP_W = 14
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sio_i,
	output logic sio_o,
	output logic sio_oe,
	input wire logic [TEMP_W-1:0] temp_in,
	output logic alert,
	output logic conv_active
);
	localparam int RES_PAD = 16 - TEMP_W;

	logic [15:0] cfg_q, stat_q, res_q, low_q, high_q, slew_q, prev_q;
	logic prev_ok_q;
	logic [31:0] prdata_q;
	logic alert_q;
	logic we, rd;
	logic [2:0] widx, ridx;
	logic [15:0] wdata;
	logic sw_q, srd_q, crc_err_q;
	logic [2:0] swi_q, sri_q;
	logic [15:0] swd_q;
	logic conv_done;
	logic single_q;
	tca_pkg::tca_conv_t cst_q;
	logic [11:0] pcnt_q;
	logic [$clog2(TICK_CYCLES+1)-1:0] tcnt_q;
	logic tick;

	function automatic logic [2:0] addr_idx(input logic [11:0] a);
		addr_idx = a[4:2];
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[1:0] == 2'h0) && (a[11:5] == 7'h00) && (a[4:2] <= `TCA_IDX_LAST);
	endfunction

	function automatic logic [15:0] reg_val(input logic [2:0] i, input logic [15:0] c,
		input logic [15:0] s, input logic [15:0] r, input logic [15:0] l,
		input logic [15:0] h, input logic [15:0] w);
		case (i)
			`TCA_IDX_CFG: reg_val = c;
			`TCA_IDX_STAT: reg_val = s;
			`TCA_IDX_RES: reg_val = r;
			`TCA_IDX_LOW: reg_val = l;
			`TCA_IDX_HIGH: reg_val = h;
			`TCA_IDX_SLEW: reg_val = w;
			default: reg_val = 16'h0000;
		endcase
	endfunction

	function automatic logic [11:0] period_ms(input logic [2:0] code);
		case (code)
			3'h0: period_ms = `TCA_PER0_MS;
			3'h1: period_ms = `TCA_PER1_MS;
			3'h2: period_ms = `TCA_PER2_MS;
			3'h3: period_ms = `TCA_PER3_MS;
			3'h4: period_ms = `TCA_PER4_MS;
			3'h5: period_ms = `TCA_PER5_MS;
			3'h6: period_ms = `TCA_PER6_MS;
			default: period_ms = `TCA_PER7_MS;
		endcase
	endfunction

	function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
		crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `TCA_CRC_POLY : 16'h0000);
	endfunction

	// ---------------- apb slave; spi register writes take priority
	logic apb_acc;
	assign apb_acc = psel && penable;
	assign pready = !sw_q;
	assign pslverr = apb_acc && !mapped(paddr);
	assign prdata = prdata_q;
	assign we = sw_q || (apb_acc && pwrite && pready && mapped(paddr));
	assign widx = sw_q ? swi_q : addr_idx(paddr);
	assign wdata = sw_q ? swd_q : pwdata[15:0];
	assign rd = srd_q || (apb_acc && !pwrite && pready && mapped(paddr));
	assign ridx = srd_q ? sri_q : addr_idx(paddr);

	// read data is refreshed every cycle of the transfer, so it is one cycle old at most
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (psel && mapped(paddr))
			prdata_q <= {16'h0000, reg_val(addr_idx(paddr), cfg_q, stat_q, res_q, low_q,
				high_q, slew_q)};
		else
			prdata_q <= 32'h0000_0000;
	end

	// ---------------- configuration and limit registers
	logic cfg_we;
	assign cfg_we = we && (widx == `TCA_IDX_CFG);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_q <= `TCA_CFG_RST;
		else if (cfg_we)
			cfg_q <= wdata & `TCA_CFG_WMASK;
		else if (conv_done && single_q)
		begin
			cfg_q[`TCA_CFG_MODE] <= 1'b1;
			cfg_q[`TCA_CFG_SHOT] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_q <= `TCA_LOW_RST;
			high_q <= `TCA_HIGH_RST;
			slew_q <= `TCA_SLEW_RST;
		end
		else if (we)
		begin
			if (widx == `TCA_IDX_LOW)
				low_q <= wdata;
			if (widx == `TCA_IDX_HIGH)
				high_q <= wdata;
			if (widx == `TCA_IDX_SLEW)
				slew_q <= wdata;
		end
	end

	// ---------------- timebase and conversion sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tcnt_q <= '0;
		else if (tick)
			tcnt_q <= '0;
		else
			tcnt_q <= tcnt_q + 1'b1;
	end
	assign tick = (tcnt_q == ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cst_q <= tca_pkg::TCA_CONV_OFF;
			pcnt_q <= 12'h000;
			single_q <= 1'b0;
		end
		else if (cfg_we && wdata[`TCA_CFG_SHOT])
		begin
			cst_q <= tca_pkg::TCA_CONV_ACT;
			pcnt_q <= 12'h000;
			single_q <= 1'b1;
		end
		else if (cfg_we && wdata[`TCA_CFG_MODE])
		begin
			cst_q <= tca_pkg::TCA_CONV_OFF;
			single_q <= 1'b0;
		end
		else if (cfg_we && cst_q == tca_pkg::TCA_CONV_OFF)
		begin
			cst_q <= tca_pkg::TCA_CONV_ACT;
			pcnt_q <= 12'h000;
		end
		else if (tick)
		begin
			case (cst_q)
				tca_pkg::TCA_CONV_ACT:
				begin
					pcnt_q <= pcnt_q + 12'h001;
					if (pcnt_q == `TCA_CONV_ACT_MS - 12'h001)
					begin
						cst_q <= single_q ? tca_pkg::TCA_CONV_OFF : tca_pkg::TCA_CONV_STBY;
						single_q <= 1'b0;
					end
				end
				tca_pkg::TCA_CONV_STBY:
				begin
					// period covers active plus standby, restarted from zero
					if (pcnt_q >= period_ms(cfg_q[`TCA_CFG_PER_HI:`TCA_CFG_PER_LO]) - 12'h001)
					begin
						cst_q <= tca_pkg::TCA_CONV_ACT;
						pcnt_q <= 12'h000;
					end
					else
						pcnt_q <= pcnt_q + 12'h001;
				end
				default: cst_q <= tca_pkg::TCA_CONV_OFF;
			endcase
		end
	end

	// completion is seen the cycle the active phase ends
	assign conv_done = tick && (cst_q == tca_pkg::TCA_CONV_ACT) && !cfg_we
		&& (pcnt_q == `TCA_CONV_ACT_MS - 12'h001);
	assign conv_active = (cst_q == tca_pkg::TCA_CONV_ACT);

	// ---------------- result, history and comparisons
	logic [15:0] new_res;
	logic signed [16:0] rise;
	logic hi_x, lo_x, slew_x, cont;
	assign new_res = {temp_in, {RES_PAD{1'b0}}};
	assign rise = $signed({new_res[15], new_res}) - $signed({prev_q[15], prev_q});
	assign cont = !cfg_q[`TCA_CFG_MODE] && !single_q;
	assign hi_x = cfg_q[`TCA_CFG_LIMEN] && ($signed(new_res) > $signed(high_q));
	assign lo_x = cfg_q[`TCA_CFG_LIMEN] && ($signed(new_res) < $signed(low_q));
	// only a rise counts, and only with a fixed interval behind it
	assign slew_x = cont && prev_ok_q && (rise > $signed({1'b0, slew_q}));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			res_q <= 16'h0000;
			prev_q <= 16'h0000;
			prev_ok_q <= 1'b0;
		end
		else if (conv_done)
		begin
			res_q <= new_res;
			prev_q <= new_res;
			prev_ok_q <= cont;
		end
		else if (cst_q == tca_pkg::TCA_CONV_OFF)
			prev_ok_q <= 1'b0;
	end

	// ---------------- status: sets win over read clears
	logic comp_chg, st_rd, res_rd, comp;
	logic [15:0] st_set, st_clr;
	assign comp = cfg_q[`TCA_CFG_COMP];
	assign comp_chg = cfg_we && (wdata[`TCA_CFG_COMP] != comp);
	assign st_rd = rd && (ridx == `TCA_IDX_STAT);
	assign res_rd = rd && (ridx == `TCA_IDX_RES);

	always_comb
	begin
		st_set = 16'h0000;
		st_clr = 16'h0000;
		if (conv_done)
		begin
			st_set[`TCA_ST_HIGH] = hi_x;
			st_set[`TCA_ST_LOW] = lo_x;
			st_set[`TCA_ST_SLEW] = slew_x;
			st_set[`TCA_ST_DRDY] = 1'b1;
			if (comp)
			begin
				// level mode tracks the latest comparison; slew holds in shutdown
				st_clr[`TCA_ST_HIGH] = 1'b1;
				st_clr[`TCA_ST_LOW] = 1'b1;
				st_clr[`TCA_ST_SLEW] = cont;
			end
		end
		st_set[`TCA_ST_CRC] = crc_err_q;
		if (st_rd || res_rd)
			st_clr[`TCA_ST_DRDY] = 1'b1;
		if (st_rd && !comp)
		begin
			st_clr[`TCA_ST_HIGH] = 1'b1;
			st_clr[`TCA_ST_LOW] = 1'b1;
			st_clr[`TCA_ST_SLEW] = 1'b1;
			st_clr[`TCA_ST_CRC] = 1'b1;
		end
		if (st_rd && comp)
			st_clr[`TCA_ST_CRC] = 1'b1;
	end

	// mode switches touch nothing here; only a pin mode change wipes status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_q <= 16'h0000;
		else if (comp_chg)
			stat_q <= 16'h0000;
		else
			stat_q <= (stat_q & ~st_clr) | st_set;
	end

	// pin drops in the same cycle the status is wiped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			alert_q <= 1'b0;
		else if (comp_chg)
			alert_q <= 1'b0;
		else
			alert_q <= (|stat_q[`TCA_ST_SLEW:`TCA_ST_HIGH])
				|| (cfg_q[`TCA_CFG_DRDYEN] && stat_q[`TCA_ST_DRDY]);
	end
	assign alert = alert_q;

	// ---------------- spi link, sampled on pclk
	logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, sio_s1, sio_s2;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			sio_s1 <= 1'b0;
			sio_s2 <= 1'b0;
		end
		else
		begin
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			sio_s1 <= sio_i;
			sio_s2 <= sio_s1;
		end
	end

	tca_pkg::tca_spi_t sp_q;
	logic [3:0] bit_q, len_q, wcnt_q, cm_q, cmi_q;
	logic [15:0] shi_q, sho_q, crc_q, crc_n, word_n;
	logic rd_q, crc_on_q, inc_q, oe_q, s_rise, s_fall, sbit;
	logic [2:0] addr_q, addr_n, cma_q;
	logic [15:0] wbuf [0:9];
	logic [3:0] w_len;

	assign s_rise = !cs_s2 && sclk_s2 && !sclk_s3;
	assign s_fall = !cs_s2 && !sclk_s2 && sclk_s3;
	// checksum covers the bits actually on the wire, from either end
	assign sbit = (sp_q == tca_pkg::TCA_SPI_DATA && rd_q) ? sho_q[15] : sio_s2;
	assign crc_n = crc_bit(crc_q, sbit);
	assign word_n = {shi_q[14:0], sio_s2};
	assign w_len = word_n[`TCA_CMD_LEN_HI:`TCA_CMD_LEN_LO];
	assign addr_n = inc_q ? addr_q + 3'h1 : addr_q;
	assign sio_o = sho_q[15];
	assign sio_oe = oe_q && !cs_s2;

	always_ff @(posedge pclk)
	begin
		if (s_rise && bit_q == 4'hF && sp_q == tca_pkg::TCA_SPI_DATA && !rd_q && crc_on_q)
			wbuf[wcnt_q] <= word_n;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sp_q <= tca_pkg::TCA_SPI_CMD;
			bit_q <= 4'h0;
			shi_q <= 16'h0000;
			sho_q <= 16'h0000;
			crc_q <= `TCA_CRC_INIT;
			{rd_q, crc_on_q, inc_q, oe_q} <= 4'h0;
			{len_q, wcnt_q, cm_q, cmi_q} <= 16'h0000;
			{addr_q, cma_q, swi_q, sri_q} <= 12'h000;
			{sw_q, srd_q, crc_err_q} <= 3'h0;
			swd_q <= 16'h0000;
		end
		else
		begin
			sw_q <= 1'b0;
			srd_q <= 1'b0;
			crc_err_q <= 1'b0;
			if (cm_q != 4'h0)
			begin
				// checked words go to the registers one per cycle after the checksum
				sw_q <= 1'b1;
				swi_q <= cma_q;
				swd_q <= wbuf[cmi_q];
				cma_q <= inc_q ? cma_q + 3'h1 : cma_q;
				cmi_q <= cmi_q + 4'h1;
				cm_q <= cm_q - 4'h1;
			end
			if (cs_s2)
			begin
				sp_q <= tca_pkg::TCA_SPI_CMD;
				bit_q <= 4'h0;
				crc_q <= `TCA_CRC_INIT;
				oe_q <= 1'b0;
			end
			else if (s_fall && bit_q != 4'h0)
				sho_q <= {sho_q[14:0], 1'b0};
			else if (s_rise)
			begin
				bit_q <= bit_q + 4'h1;
				shi_q <= word_n;
				if (sp_q != tca_pkg::TCA_SPI_CRC)
					crc_q <= crc_n;
				if (bit_q == 4'hF)
				begin
					case (sp_q)
						tca_pkg::TCA_SPI_CMD:
						begin
							// invalid length silently turns the checksum off
							crc_on_q <= word_n[`TCA_CMD_CRC] && w_len != 4'h0
								&& w_len <= `TCA_LEN_MAX;
							len_q <= w_len;
							rd_q <= word_n[`TCA_CMD_READ];
							inc_q <= word_n[`TCA_CMD_INC];
							addr_q <= word_n[2:0];
							cma_q <= word_n[2:0];
							wcnt_q <= 4'h0;
							sp_q <= tca_pkg::TCA_SPI_DATA;
							if (word_n[`TCA_CMD_READ])
							begin
								sho_q <= reg_val(word_n[2:0], cfg_q, stat_q, res_q, low_q,
									high_q, slew_q);
								srd_q <= 1'b1;
								sri_q <= word_n[2:0];
								oe_q <= 1'b1;
							end
						end
						tca_pkg::TCA_SPI_DATA:
						begin
							wcnt_q <= wcnt_q + 4'h1;
							addr_q <= addr_n;
							if (crc_on_q && wcnt_q + 4'h1 == len_q)
							begin
								sp_q <= tca_pkg::TCA_SPI_CRC;
								if (rd_q)
									sho_q <= crc_n;
							end
							else if (rd_q)
							begin
								sho_q <= reg_val(addr_n, cfg_q, stat_q, res_q, low_q,
									high_q, slew_q);
								srd_q <= 1'b1;
								sri_q <= addr_n;
							end
							else if (!crc_on_q)
							begin
								sw_q <= 1'b1;
								swi_q <= addr_q;
								swd_q <= word_n;
							end
						end
						tca_pkg::TCA_SPI_CRC:
						begin
							sp_q <= tca_pkg::TCA_SPI_END;
							oe_q <= 1'b0;
							if (!rd_q && word_n == crc_q)
							begin
								cm_q <= len_q;
								cmi_q <= 4'h0;
							end
							else if (!rd_q)
								crc_err_q <= 1'b1;
						end
						default: sp_q <= tca_pkg::TCA_SPI_END;
					endcase
				end
			end
		end
	end
endmodule

// file: design/tca_map.svh
`ifndef TCA_MAP_SVH
`define TCA_MAP_SVH

// apb byte offsets, one 32-bit word per register
`define TCA_OFF_CFG 12'h000
`define TCA_OFF_STAT 12'h004
`define TCA_OFF_RES 12'h008
`define TCA_OFF_LOW 12'h00C
`define TCA_OFF_HIGH 12'h010
`define TCA_OFF_SLEW 12'h014

// register index, also the spi sub-address
`define TCA_IDX_CFG 3'h0
`define TCA_IDX_STAT 3'h1
`define TCA_IDX_RES 3'h2
`define TCA_IDX_LOW 3'h3
`define TCA_IDX_HIGH 3'h4
`define TCA_IDX_SLEW 3'h5
`define TCA_IDX_LAST 3'h5

// configuration fields
`define TCA_CFG_MODE 0
`define TCA_CFG_SHOT 1
`define TCA_CFG_COMP 2
`define TCA_CFG_LIMEN 3
`define TCA_CFG_DRDYEN 4
`define TCA_CFG_PER_LO 5
`define TCA_CFG_PER_HI 7
`define TCA_CFG_WMASK 16'h00FF
`define TCA_CFG_RST 16'h0008

// status fields
`define TCA_ST_HIGH 0
`define TCA_ST_LOW 1
`define TCA_ST_SLEW 2
`define TCA_ST_DRDY 3
`define TCA_ST_CRC 4

// limit reset values
`define TCA_LOW_RST 16'hEC00
`define TCA_HIGH_RST 16'h3E80
`define TCA_SLEW_RST 16'h0100

// spi command word fields
`define TCA_CMD_CRC 14
`define TCA_CMD_LEN_HI 13
`define TCA_CMD_LEN_LO 10
`define TCA_CMD_INC 9
`define TCA_CMD_READ 8
`define TCA_LEN_MAX 4'hA
`define TCA_CRC_POLY 16'h8005
`define TCA_CRC_INIT 16'hFFFF

// timing
`define TCA_CLK_PERIOD_NS 10
`define TCA_TICK_PERIOD_NS 1000000
`define TCA_CONV_ACT_MS 12'h008
`define TCA_PER0_MS 12'h010
`define TCA_PER1_MS 12'h020
`define TCA_PER2_MS 12'h040
`define TCA_PER3_MS 12'h07D
`define TCA_PER4_MS 12'h0FA
`define TCA_PER5_MS 12'h1F4
`define TCA_PER6_MS 12'h3E8
`define TCA_PER7_MS 12'hFA0

`endif

// file: design/tca_pkg.sv
package tca_pkg;
	typedef enum logic [1:0]
	{
		TCA_CONV_OFF = 2'b00,
		TCA_CONV_ACT = 2'b01,
		TCA_CONV_STBY = 2'b10
	} tca_conv_t;

	typedef enum logic [1:0]
	{
		TCA_SPI_CMD = 2'b00,
		TCA_SPI_DATA = 2'b01,
		TCA_SPI_CRC = 2'b10,
		TCA_SPI_END = 2'b11
	} tca_spi_t;
endpackage

// file: dv/tca_ctrl_properties.sv
`timescale 1ns/10ps
module tca_ctrl_properties #(
	parameter int TICK_CYCLES = 10,
	parameter int TEMP_W = 14
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sio_i,
	input wire logic sio_o,
	input wire logic sio_oe,
	input wire logic [TEMP_W-1:0] temp_in,
	input wire logic alert,
	input wire logic conv_active
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence cfg_wr;
		psel && penable && pready && pwrite && paddr == 12'h000;
	endsequence
	sequence shot_wr;
		cfg_wr ##0 pwdata[1];
	endsequence
	sequence stop_wr;
		cfg_wr ##0 (pwdata[0] && !pwdata[1]);
	endsequence
	// a checked spi burst commits up to ten words, one stall cycle each
	chk_wait_once: assert property (psel && penable && !pready |-> ##[1:10] pready)
		else $error("register access stalled too long");
	chk_err_phase: assert property (pslverr |-> psel && penable)
		else $error("error response outside access phase");
	chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	chk_upper_zero: assert property (psel && penable && pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	chk_stop_now: assert property (stop_wr |=> ##[0:3] !conv_active)
		else $error("shutdown did not stop the conversion");
	chk_shot_start: assert property (shot_wr |=> ##[0:3] conv_active)
		else $error("single shot did not start a conversion");
	chk_active_min: assert property ($rose(conv_active) |-> conv_active[*8])
		else $error("active conversion cut short");
	chk_standby_min: assert property ($fell(conv_active) |-> !conv_active[*8])
		else $error("standby missing after conversion");
	chk_oe_frame: assert property (sio_oe |-> !$past(cs_n, 6))
		else $error("data line driven while deselected");
endmodule

bind tca_ctrl tca_ctrl_properties #(.TICK_CYCLES(TICK_CYCLES), .TEMP_W(TEMP_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sclk(sclk), .cs_n(cs_n), .sio_i(sio_i), .sio_o(sio_o), .sio_oe(sio_oe),
	.temp_in(temp_in), .alert(alert), .conv_active(conv_active));

// file: dv/tca_spi_host.sv
`timescale 1ns/10ps
module tca_spi_host (
	output logic sclk,
	output logic cs_n,
	output logic sio_i,
	input wire logic sio_o,
	input wire logic sio_oe
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sio_i = 1'b1;
	end
	// command in w[47:32], then up to two words; after a read command the device owns the line
	task automatic frame(input logic [47:0] w, input int n, output logic [47:0] r);
		logic rd_cmd;
		rd_cmd = w[40];
		r = '0;
		if (!rd_cmd && w[34:32] == 3'h0)
			w[46] = 1'b0;
		#3 cs_n = 1'b0;
		#100;
		for (int i = 47; i > 47 - 16 * n; i--)
		begin
			// a released line toggles so a stale level is never mistaken for data
			sio_i = (i > 31 || !rd_cmd) ? w[i] : ~sio_i;
			#80 sclk = 1'b1;
			r[i] = sio_oe ? sio_o : 1'bx;
			#80 sclk = 1'b0;
		end
		#40 cs_n = 1'b1;
		sio_i = ~sio_i;
		#200;
	endtask
endmodule

// file: dv/tb_top.sv
`timescale 1ns/10ps
`include "tca_map.svh"
`define CHK(a, b) \
	begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
	localparam int TK = 10;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, v;
	logic pready, pslverr, sclk, cs_n, sio_i, sio_o, sio_oe, alert, conv_active, err;
	logic [13:0] temp_in = 14'h0320;
	logic [47:0] r;
	int n, error_cnt = 0, checks = 0;
	always #5 pclk = ~pclk;
	tca_ctrl #(.TICK_CYCLES(TK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .sio_i(sio_i),
		.sio_o(sio_o), .sio_oe(sio_oe), .temp_in(temp_in), .alert(alert),
		.conv_active(conv_active));
	tca_spi_host host (.sclk(sclk), .cs_n(cs_n), .sio_i(sio_i), .sio_o(sio_o), .sio_oe(sio_oe));
	function automatic logic [15:0] crc16(input logic [31:0] d);
		logic [15:0] c;
		c = `TCA_CRC_INIT;
		for (int i = 31; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `TCA_CRC_POLY : 16'h0000);
		return c;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		// a slave that never answers counts as a mismatch
		if (pready !== 1'b1)
			error_cnt++;
		v = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		apb(1'b0, a, 16'h0000);
		`CHK(v, {16'h0000, e})
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
	endtask
	// counts edges until the conversion flag reaches the wanted level
	task automatic wait_lvl(input logic l);
		n = 0;
		while (conv_active !== l && n < 9000)
		begin
			@(posedge pclk);
			n++;
		end
		`CHK(n < 9000, 1'b1)
	endtask
	task automatic conv;
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		repeat (3) @(posedge pclk);
	endtask
	task automatic t_reset;
		rd(`TCA_OFF_CFG, `TCA_CFG_RST);
		rd(`TCA_OFF_STAT, 16'h0000);
		rd(`TCA_OFF_RES, 16'h0000);
		rd(`TCA_OFF_LOW, `TCA_LOW_RST);
		rd(`TCA_OFF_HIGH, `TCA_HIGH_RST);
		rd(`TCA_OFF_SLEW, `TCA_SLEW_RST);
		apb(1'b0, 12'h018, 16'h0000);
		`CHK(err, 1'b1)
	endtask
	task automatic t_conv;
		wr(`TCA_OFF_CFG, 16'h0008);
		conv();
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		`CHK(n, 8 * TK)
		wait_lvl(1'b1);
		`CHK(n, 8 * TK)
		wr(`TCA_OFF_CFG, 16'h0028);
		conv();
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		`CHK(n, 24 * TK)
		conv();
		rd(`TCA_OFF_STAT, 16'h0008);
		rd(`TCA_OFF_STAT, 16'h0000);
		conv();
		rd(`TCA_OFF_RES, 16'h0C80);
		rd(`TCA_OFF_STAT, 16'h0000);
	endtask
	task automatic t_limits;
		temp_in <= 14'h1000;
		conv();
		`CHK(alert, 1'b1)
		rd(`TCA_OFF_STAT, 16'h000D);
		// the pin follows the status register one cycle later
		repeat (2) @(posedge pclk);
		`CHK(alert, 1'b0)
		temp_in <= 14'h3000;
		conv();
		rd(`TCA_OFF_STAT, 16'h000A);
		conv();
		`CHK(alert, 1'b1)
		wr(`TCA_OFF_CFG, 16'h002C);
		@(posedge pclk);
		`CHK(alert, 1'b0)
		rd(`TCA_OFF_STAT, 16'h0000);
		wr(`TCA_OFF_CFG, 16'h0024);
		conv();
		`CHK(alert, 1'b0)
		rd(`TCA_OFF_STAT, 16'h0008);
		wr(`TCA_OFF_CFG, 16'h0034);
		conv();
		`CHK(alert, 1'b1)
		rd(`TCA_OFF_RES, 16'hC000);
		repeat (2) @(posedge pclk);
		`CHK(alert, 1'b0)
		wr(`TCA_OFF_CFG, 16'h0028);
	endtask
	task automatic t_slew;
		temp_in <= 14'h0320;
		conv();
		apb(1'b0, `TCA_OFF_STAT, 16'h0000);
		temp_in <= 14'h0360;
		conv();
		rd(`TCA_OFF_STAT, 16'h0008);
		temp_in <= 14'h03A1;
		conv();
		rd(`TCA_OFF_STAT, 16'h000C);
	endtask
	task automatic t_modes;
		temp_in <= 14'h1000;
		conv();
		wr(`TCA_OFF_CFG, 16'h0029);
		@(posedge pclk);
		`CHK(alert, 1'b1)
		temp_in <= 14'h0100;
		repeat (20) @(posedge pclk);
		wr(`TCA_OFF_CFG, 16'h0028);
		wait_lvl(1'b1);
		repeat (20) @(posedge pclk);
		wr(`TCA_OFF_CFG, 16'h0029);
		repeat (200) @(posedge pclk);
		// status first: a result read would clear the done flag
		rd(`TCA_OFF_STAT, 16'h000D);
		rd(`TCA_OFF_RES, 16'h4000);
		temp_in <= 14'h0200;
		wr(`TCA_OFF_CFG, 16'h002B);
		repeat (40) @(posedge pclk);
		wr(`TCA_OFF_CFG, 16'h002B);
		repeat (50) @(posedge pclk);
		rd(`TCA_OFF_RES, 16'h4000);
		conv();
		rd(`TCA_OFF_CFG, 16'h0029);
		rd(`TCA_OFF_STAT, 16'h0008);
		rd(`TCA_OFF_RES, 16'h0800);
		temp_in <= 14'h0800;
		wr(`TCA_OFF_CFG, 16'h002B);
		conv();
		rd(`TCA_OFF_STAT, 16'h0008);
	endtask
	task automatic t_spi;
		repeat (10) @(posedge pclk);
		wr(`TCA_OFF_CFG, 16'h0028);
		conv();
		host.frame({16'h4502, 32'h0}, 3, r);
		`CHK(r[31:16], 16'h2000)
		`CHK(r[15:0], crc16({16'h4502, 16'h2000}))
		host.frame({16'h4403, 16'hF000, crc16({16'h4403, 16'hF000})}, 3, r);
		rd(`TCA_OFF_LOW, 16'hF000);
		host.frame({16'h4403, 16'hE000, ~crc16({16'h4403, 16'hE000})}, 3, r);
		rd(`TCA_OFF_LOW, 16'hF000);
		apb(1'b0, `TCA_OFF_STAT, 16'h0000);
		`CHK(v[`TCA_ST_CRC], 1'b1)
		host.frame({16'h6E03, 16'hE400, 16'h3E00}, 3, r);
		rd(`TCA_OFF_LOW, 16'hE400);
		rd(`TCA_OFF_HIGH, 16'h3E00);
	endtask
	task automatic complete_run;
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#400000;
		error_cnt++;
		complete_run;
	end
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_conv;
		t_limits;
		t_slew;
		t_modes;
		t_spi;
		complete_run;
	end
endmodule
